// [design/wpw_defs.svh]
`ifndef WPW_DEFS_SVH
`define WPW_DEFS_SVH

// Reference clock
`define WPW_CLK_KHZ 25000

// Sampling interval per timing mode, microseconds
`define WPW_TSAM_FAST_US 500
`define WPW_TSAM_SLOW_US 1000
`define WPW_TSAM_FAST_CYC ((`WPW_TSAM_FAST_US * `WPW_CLK_KHZ) / 1000)
`define WPW_TSAM_SLOW_CYC ((`WPW_TSAM_SLOW_US * `WPW_CLK_KHZ) / 1000)

// Watchdog period and ignore window, microseconds
`define WPW_PERIOD_FAST_US 32000
`define WPW_PERIOD_SLOW_US 64000
`define WPW_IGNORE_FAST_US 32000
`define WPW_IGNORE_SLOW_US 64000

// Both modes hold the same number of sampling intervals
`define WPW_WIN_SAMPLES (`WPW_PERIOD_FAST_US / `WPW_TSAM_FAST_US)
`define WPW_IGN_SAMPLES (`WPW_IGNORE_FAST_US / `WPW_TSAM_FAST_US)

// Release delay, microseconds
`define WPW_RD_US 8000
`define WPW_RD_CYC ((`WPW_RD_US * `WPW_CLK_KHZ) / 1000)

// Counter widths
`define WPW_DLY_W 20
`define WPW_TICK_W 16
`define WPW_SMP_W 8

// Sample history: two highs then two lows, oldest in the top bit
`define WPW_TRIG_PATTERN 4'hC
`define WPW_HIST_FULL 3'h4

`endif

// [design/wpw_pkg.sv]
`include "wpw_defs.svh"

package wpw_pkg;

   typedef enum logic [1:0] {
      WPW_HOLD = 2'h0,
      WPW_IGNORE = 2'h1,
      WPW_TRIG = 2'h3,
      WPW_GAP = 2'h2
   } wpw_state_e;

   typedef struct packed {
      logic [3:0] meta;
      logic [3:0] sync;
      logic sg;
      logic [`WPW_DLY_W-1:0] sg_cnt;
      wpw_state_e st;
      logic [`WPW_DLY_W-1:0] dly_cnt;
      logic [`WPW_SMP_W-1:0] smp_cnt;
      logic [3:0] hist;
      logic [2:0] nhist;
      logic slow;
      logic restart;
      logic fail_oe;
      logic sg_oe;
      logic pin_lvl;
   } wpw_top_s;

   typedef struct packed {
      logic [`WPW_TICK_W-1:0] cnt;
      logic tick;
   } wpw_tick_s;

endpackage

// [design/wpw_tick_if.sv]
`timescale 1ns/1ns

interface wpw_tick_if;
   logic restart;
   logic slow;
   logic tick;

   modport gen (
      input restart,
      input slow,
      output tick
   );

   modport user (
      output restart,
      output slow,
      input tick
   );
endinterface

// [design/wpw_tick_gen.sv]
`timescale 1ns/1ns

`include "wpw_defs.svh"

module wpw_tick_gen
   import wpw_pkg::*;
#(
   parameter int FAST_CYC = `WPW_TSAM_FAST_CYC,
   parameter int SLOW_CYC = `WPW_TSAM_SLOW_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Tick channel
   wpw_tick_if.gen tk
);

   localparam int TW = `WPW_TICK_W;
   localparam logic [TW-1:0] FAST_LAST = TW'(FAST_CYC - 1);
   localparam logic [TW-1:0] SLOW_LAST = TW'(SLOW_CYC - 1);

   generate
      if (FAST_CYC < 1 || SLOW_CYC < 1 || FAST_CYC >= (1 << TW) || SLOW_CYC >= (1 << TW)) begin : g_bad
         $error("Sampling interval does not fit the tick counter");
      end
   endgenerate

   wpw_tick_s q;
   wpw_tick_s d;

   // One pulse per sampling interval, phase restarted on request
   always_comb begin
      d = q;
      d.tick = 1'b0;
      if (tk.restart) begin
         d.cnt = '0;
      end else if (q.cnt == (tk.slow ? SLOW_LAST : FAST_LAST)) begin
         d.cnt = '0;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt + TW'(1);
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tk.tick = q.tick;

endmodule

// [design/wpw_top.sv]
`timescale 1ns/1ns

`include "wpw_defs.svh"

module wpw_top
   import wpw_pkg::*;
#(
   parameter int RD_CYCLES = `WPW_RD_CYC,
   parameter int TSAM_FAST_CYCLES = `WPW_TSAM_FAST_CYC,
   parameter int TSAM_SLOW_CYCLES = `WPW_TSAM_SLOW_CYC,
   parameter int WIN_SAMPLES = `WPW_WIN_SAMPLES,
   parameter int IGN_SAMPLES = `WPW_IGN_SAMPLES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Pins from outside
   input wire logic trigger_in,
   input wire logic timing_select,
   input wire logic vcc_above_thr,
   input wire logic supply_under,
   // Open-collector supply-good pin
   output logic supply_good_out_o,
   output logic supply_good_out_oe,
   // Open-collector failure pin
   output logic failure_out_o,
   output logic failure_out_oe
);

   localparam int DW = `WPW_DLY_W;
   localparam int SW = `WPW_SMP_W;
   localparam logic [DW-1:0] RD_LAST = DW'(RD_CYCLES - 1);
   localparam logic [SW-1:0] WIN_LAST = SW'(WIN_SAMPLES - 2);
   localparam logic [SW-1:0] IGN_LAST = SW'(IGN_SAMPLES - 1);

   generate
      if (RD_CYCLES < 1 || RD_CYCLES >= (1 << DW)) begin : g_bad_rd
         $error("Release delay does not fit its counter");
      end
      if (WIN_SAMPLES < 6 || WIN_SAMPLES >= (1 << SW) || IGN_SAMPLES < 1 || IGN_SAMPLES >= (1 << SW)) begin : g_bad_win
         $error("Window sample counts out of range");
      end
   endgenerate

   wpw_tick_if tk ();

   wpw_tick_gen #(
      .FAST_CYC(TSAM_FAST_CYCLES),
      .SLOW_CYC(TSAM_SLOW_CYCLES)
   ) u_tick (
      .ref_clk(ref_clk),
      .rst(rst),
      .tk(tk)
   );

   wpw_top_s q;
   wpw_top_s d;

   // Synchronised pin levels
   logic trig_s;
   logic sel_s;
   logic vcc_s;
   logic uv_s;
   // Sampler view
   logic [3:0] hist_n;
   logic [2:0] nhist_n;
   logic trig_ok;

   assign trig_s = q.sync[0];
   assign sel_s = q.sync[1];
   assign vcc_s = q.sync[2];
   assign uv_s = q.sync[3];

   // Next history once this sample is shifted in
   assign hist_n = {q.hist[2:0], trig_s};
   assign nhist_n = (q.nhist == `WPW_HIST_FULL) ? q.nhist : q.nhist + 3'h1;
   assign trig_ok = (nhist_n == `WPW_HIST_FULL) && (hist_n == `WPW_TRIG_PATTERN);

   always_comb begin
      d = q;
      d.restart = 1'b0;
      d.pin_lvl = 1'b0;

      // Two-stage synchronisers
      d.meta = {supply_under, vcc_above_thr, timing_select, trigger_in};
      d.sync = q.meta;

      // Supply-good generator, independent of the watchdog
      if (!vcc_s || uv_s) begin
         d.sg = 1'b0;
         d.sg_cnt = '0;
      end else if (!q.sg) begin
         if (q.sg_cnt == RD_LAST) begin
            d.sg = 1'b1;
         end else begin
            d.sg_cnt = q.sg_cnt + DW'(1);
         end
      end
      d.sg_oe = !d.sg;

      case (q.st)
         WPW_HOLD: begin
            d.fail_oe = 1'b1;
            // Tick phase parked, no stale tick may shorten the ignore window
            d.restart = 1'b1;
            if (!q.sg) begin
               d.dly_cnt = '0;
            end else if (q.dly_cnt == RD_LAST) begin
               d.fail_oe = 1'b0;
               d.st = WPW_IGNORE;
               d.smp_cnt = '0;
               d.slow = sel_s;
               d.restart = 1'b1;
            end else begin
               d.dly_cnt = q.dly_cnt + DW'(1);
            end
         end
         WPW_IGNORE: begin
            // Trigger samples are not looked at here
            if (tk.tick) begin
               if (q.smp_cnt == IGN_LAST) begin
                  d.st = WPW_TRIG;
                  d.smp_cnt = '0;
                  d.hist = '0;
                  d.nhist = '0;
                  d.slow = sel_s;
                  d.restart = 1'b1;
               end else begin
                  d.smp_cnt = q.smp_cnt + SW'(1);
               end
            end
         end
         WPW_TRIG: begin
            if (tk.tick) begin
               d.hist = hist_n;
               d.nhist = nhist_n;
               if (trig_ok) begin
                  d.st = WPW_GAP;
                  d.restart = 1'b1;
               end else if (q.smp_cnt == WIN_LAST) begin
                  d.st = WPW_HOLD;
                  d.fail_oe = 1'b1;
                  d.dly_cnt = '0;
               end else begin
                  d.smp_cnt = q.smp_cnt + SW'(1);
               end
            end
         end
         WPW_GAP: begin
            // Samples taken here are dropped, the next window starts clean
            if (tk.tick) begin
               d.st = WPW_TRIG;
               d.smp_cnt = '0;
               d.hist = '0;
               d.nhist = '0;
               d.slow = sel_s;
               d.restart = 1'b1;
            end
         end
         default: begin
            d.st = WPW_HOLD;
            d.fail_oe = 1'b1;
            d.dly_cnt = '0;
         end
      endcase

      // Supply-good low overrides any watchdog activity
      if (!d.sg) begin
         d.st = WPW_HOLD;
         d.fail_oe = 1'b1;
         d.dly_cnt = '0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q <= '{meta: 4'h0, sync: 4'h0, sg: 1'b0, sg_cnt: '0, st: WPW_HOLD, dly_cnt: '0,
                smp_cnt: '0, hist: 4'h0, nhist: 3'h0, slow: 1'b0, restart: 1'b1,
                fail_oe: 1'b1, sg_oe: 1'b1, pin_lvl: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign tk.restart = q.restart;
   assign tk.slow = q.slow;

   assign supply_good_out_o = q.pin_lvl;
   assign supply_good_out_oe = q.sg_oe;
   assign failure_out_o = q.pin_lvl;
   assign failure_out_oe = q.fail_oe;

endmodule

// [tb/wpw_top_assertions.sv]
`timescale 1ns/1ns

module wpw_chk
   import wpw_pkg::*;
#(
   parameter int RD_CYCLES = 20,
   parameter int TSAM_FAST_CYCLES = 4,
   parameter int WIN_SAMPLES = 8,
   parameter int IGN_SAMPLES = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Supply inputs
   input wire logic vcc_above_thr,
   input wire logic supply_under,
   // Open-collector pins
   input wire logic supply_good_out_o,
   input wire logic supply_good_out_oe,
   input wire logic failure_out_o,
   input wire logic failure_out_oe
);
   int sg_run, hold_run, pin_run;
   logic [3:0] bad_h;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Run lengths of supply-good cause, failure hold and released pin
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sg_run <= 0;
         hold_run <= 0;
         pin_run <= 0;
         bad_h <= 4'hF;
      end else begin
         sg_run <= (vcc_above_thr && !supply_under) ? sg_run + 1 : 0;
         hold_run <= (failure_out_oe && !supply_good_out_oe) ? hold_run + 1 : 0;
         pin_run <= failure_out_oe ? 0 : pin_run + 1;
         bad_h <= {bad_h[2:0], supply_under || !vcc_above_thr};
      end
   end
   a_reset_both_low: assert property ($past(rst) |-> supply_good_out_oe && failure_out_oe)
      else $error("pins not low after reset");
   a_pins_pull_only: assert property (failure_out_o == 1'b0 && supply_good_out_o == 1'b0)
      else $error("pin drive level not low");
   a_sg_forces_fail: assert property (supply_good_out_oe |-> failure_out_oe)
      else $error("failure pin released while supply-good low");
   a_uv_pulls_both: assert property ($rose(supply_under) |-> ##[2:4] (supply_good_out_oe && failure_out_oe))
      else $error("undervoltage did not pull both pins");
   a_sg_release_delay: assert property ($fell(supply_good_out_oe) |-> sg_run >= RD_CYCLES && sg_run <= RD_CYCLES + 4)
      else $error("supply-good release delay wrong");
   a_hold_delay: assert property ($fell(failure_out_oe) |-> hold_run >= RD_CYCLES - 1 && hold_run <= RD_CYCLES + 2)
      else $error("failure hold length wrong");
   a_no_early_miss: assert property ($rose(failure_out_oe) && !supply_good_out_oe |->
      pin_run >= (IGN_SAMPLES + WIN_SAMPLES - 1) * TSAM_FAST_CYCLES - 2)
      else $error("failure before ignore and window elapsed");
   a_sg_own_cause: assert property ($rose(supply_good_out_oe) |-> bad_h != 4'h0)
      else $error("supply-good dropped without supply cause");
endmodule

bind wpw_top wpw_chk #(.RD_CYCLES(RD_CYCLES), .TSAM_FAST_CYCLES(TSAM_FAST_CYCLES), .WIN_SAMPLES(WIN_SAMPLES),
   .IGN_SAMPLES(IGN_SAMPLES)) chk (.ref_clk(ref_clk), .rst(rst), .vcc_above_thr(vcc_above_thr),
   .supply_under(supply_under), .supply_good_out_o(supply_good_out_o), .supply_good_out_oe(supply_good_out_oe),
   .failure_out_o(failure_out_o), .failure_out_oe(failure_out_oe));

// [tb/wpw_host.sv]
`timescale 1ns/1ns

module wpw_host #(
   parameter int TF = 4,
   parameter int TS = 8
) (
   // Clock
   input wire logic ref_clk,
   // Control
   input wire logic timing_select,
   input wire logic [1:0] mode,
   // Trigger pin
   output logic trigger_in
);
   int cnt = 0;
   logic [1:0] ph = 2'h0;
   logic [3:0] pat;
   initial trigger_in = 1'b0;
   // One chunk per sample interval; mode 1 high-high-low-low, mode 2 single high
   always @(negedge ref_clk) begin
      pat = (mode == 2'h1) ? 4'hC : (mode == 2'h2) ? 4'h8 : 4'h0;
      if (cnt >= (timing_select ? TS : TF) - 1) begin
         cnt <= 0;
         ph <= ph + 2'h1;
      end else begin
         cnt <= cnt + 1;
      end
      trigger_in <= pat[2'h3 - ph];
   end
endmodule

// [tb/windowed_processor_watchdog_bench.sv]
`timescale 1ns/1ns

module windowed_processor_watchdog_bench;
   localparam int RD = 20, TF = 4, TS = 8, WIN = 8, IGN = 4;
   // Ignore and trigger window each add two cycles of tick restart
   localparam int EF = (IGN + WIN - 1) * TF + 4, ES = (IGN + WIN - 1) * TS + 4;
   typedef struct {int lo; int hi; logic sg;} wpw_note_s;
   wpw_note_s nq[$];
   wpw_note_s n;
   logic ref_clk, rst, timing_select, vcc_above_thr, supply_under, trigger_in;
   logic [1:0] mode;
   logic sg_o, sg_oe, fo_o, fo_oe;
   int bad_count = 0, compares = 0, span = 0, k, i;
   always #20 ref_clk = ~ref_clk;
   wpw_top #(.RD_CYCLES(RD), .TSAM_FAST_CYCLES(TF), .TSAM_SLOW_CYCLES(TS), .WIN_SAMPLES(WIN),
      .IGN_SAMPLES(IGN)) dut (.ref_clk(ref_clk), .rst(rst), .trigger_in(trigger_in),
      .timing_select(timing_select), .vcc_above_thr(vcc_above_thr), .supply_under(supply_under),
      .supply_good_out_o(sg_o), .supply_good_out_oe(sg_oe), .failure_out_o(fo_o), .failure_out_oe(fo_oe));
   wpw_host #(.TF(TF), .TS(TS)) host (.ref_clk(ref_clk), .timing_select(timing_select), .mode(mode),
      .trigger_in(trigger_in));
   task automatic close_out;
      if (bad_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic note(int lo, int hi, logic sg);
      nq.push_back('{lo, hi, sg});
   endtask
   // Bounded wait until the failure pin is released, or until every note is consumed
   task automatic wait_for(logic drained);
      for (i = 0; i < 3000 && (drained ? nq.size() != 0 : fo_oe !== 1'b0); i++) @(negedge ref_clk);
      if (i == 3000) begin
         bad_count++;
         close_out();
      end
   endtask
   // Pin-high span measured up to each failure pull-down
   always @(negedge ref_clk) begin
      if (fo_oe === 1'b0) begin
         span = span + 1;
      end else if (span != 0) begin
         compares++;
         if (nq.size() != 0) begin
            n = nq.pop_front();
         end else begin
            n = '{-1, -1, 1'b0};
         end
         if (span < n.lo || span > n.hi || sg_oe !== n.sg || fo_o !== 1'b0 || sg_o !== 1'b0) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h sg=%h", $time, span, n.lo, sg_oe);
         end
         span = 0;
      end
   end
   initial begin
      ref_clk = 0;
      rst = 1;
      timing_select = 0;
      vcc_above_thr = 1;
      supply_under = 0;
      mode = 2'h0;
      void'($urandom(74));
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk) rst = 0;
      note(EF - 1, EF + 1, 1'b0);
      wait_for(1);
      timing_select = 1;
      note(ES - 1, ES + 1, 1'b0);
      wait_for(1);
      timing_select = 0;
      mode = 2'h2;
      note(EF - 1, EF + 1, 1'b0);
      wait_for(1);
      mode = 2'h1;
      note(800, 99999, 1'b0);
      // Select flips inside a fast ignore window; slow applies at the window opening
      wait_for(0);
      repeat (8) @(negedge ref_clk);
      timing_select = 1;
      repeat (800) @(negedge ref_clk);
      mode = 2'h0;
      wait_for(1);
      timing_select = 0;
      for (k = 0; k < 2; k++) begin
         wait_for(0);
         mode = 2'h1;
         repeat (20 + $urandom % 60) @(negedge ref_clk);
         note(1, 99999, 1'b1);
         if (k == 0) vcc_above_thr = 0;
         else supply_under = 1;
         repeat (4 + $urandom % 8) @(negedge ref_clk);
         vcc_above_thr = 1;
         supply_under = 0;
         wait_for(1);
      end
      mode = 2'h0;
      note(EF - 1, EF + 1, 1'b0);
      wait_for(1);
      close_out();
   end
endmodule
